// ===== include/tsm_pkg.sv
// Constants shared by the tributary slot multiplexer
package tsm_pkg;
    localparam int TSM_SLOTS_PER_LANE = 20;
    localparam int TSM_PORT_W = 14;
    localparam int TSM_CM_W = 10;
    localparam int TSM_CND_W = 18;
    localparam int TSM_WORD_W = 128;
    localparam logic [4:0] TSM_MFC_RST = 5'h00;
    localparam logic [4:0] TSM_MFC_LAST = 5'h13;
    localparam logic [7:0] TSM_FA_ALIGN = 8'h00;
    localparam logic [7:0] TSM_PT_MUX = 8'h16;
    localparam logic [7:0] TSM_PSI_PT_POS = 8'h00;
    localparam logic [7:0] TSM_PSI_MSI_FIRST = 8'h02;
    localparam logic [7:0] TSM_PSI_MSI_LAST = 8'h29;
    localparam logic [1:0] TSM_OH_ROW_FIRST = 2'h1;
    localparam logic [1:0] TSM_OH_ROW_LAST = 2'h3;
    localparam int TSM_PAY_COLS_PER_TS = 119;
    localparam int TSM_PAY_ROWS = 8;
    localparam int TSM_PAY_BYTES_PER_TS = 15232;
    localparam int TSM_M_PER_TS = 128;
    localparam int TSM_N_GRAN = 8;
    localparam logic [7:0] TSM_BYTE_RST = 8'h00;
endpackage

// ===== design/tsm_mux.sv
// Tributary slot multiplexer: overhead builder and payload slot mapper
// Summary of operation
// - Payload area is 119*ts columns by 8 rows
// - Unit overhead sits in its last slot
// - Slots used in ascending global index order
// - Each payload word goes to next listed slot
// - Unused slot overhead bytes carry zeros
// - Descriptor bytes at positions 2..41, two per slot
// - Descriptor bit 1 flags slot availability
// - Descriptor bit 9 flags slot allocation
// - Fourteen descriptor bits carry tributary port number
// - Unallocated slot sends port number zero
// - Reserved structure bytes are sent as zero
// - Payload type code is 22
// - Control bytes 1-3 carry count, flags, CRC-6
// - Residual sum and CRC-9 in remaining bits
// - Word granularity is 128 times slot count
// - Residual timing granularity is 8 bits
// - Word count decides data versus stuff groups
// - Multiframe counter advances once per frame
// - Optional alignment to frame alignment counter zero
// - Same counter value goes to every lane
// - Counter value selects overhead slot A.1..A.20
// - Stuff words are all zero bytes
`timescale 1ns/1ps
`default_nettype none

module tsm_mux #(
    parameter int N_LANES = 1,
    parameter logic [5:0] CRC6_POLY = 6'h21,
    parameter logic [8:0] CRC9_POLY = 9'h101,
    localparam int NS = tsm_pkg::TSM_SLOTS_PER_LANE * N_LANES,
    localparam int SW = $clog2(NS + 1)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Frame timing
    input wire logic frame_start,
    input wire logic [7:0] fa_count,
    input wire logic align_en,
    output logic [7:0] mfc_byte,
    output logic [4:0] mfc_value,
    // Slot configuration, index n*(B-1)+A-1
    input wire logic [NS-1:0] slot_unavail,
    input wire logic [NS-1:0] slot_alloc,
    input wire logic [NS*tsm_pkg::TSM_PORT_W-1:0] slot_port,
    // Payload structure bytes
    input wire logic psi_req,
    input wire logic [7:0] psi_lane,
    input wire logic [7:0] psi_pos,
    output logic psi_valid,
    output logic [7:0] psi_byte,
    // Slot overhead bytes and justification values from the mapper
    input wire logic oh_req,
    input wire logic [7:0] oh_lane,
    input wire logic [1:0] oh_row,
    input wire logic oh_col16,
    output logic [tsm_pkg::TSM_PORT_W-1:0] jc_port,
    input wire logic [tsm_pkg::TSM_CM_W-1:0] jc_cm,
    input wire logic jc_inc,
    input wire logic jc_dec,
    input wire logic [tsm_pkg::TSM_CND_W-1:0] jc_cnd,
    output logic oh_valid,
    output logic [7:0] oh_byte,
    // Payload words
    input wire logic pay_req,
    input wire logic [tsm_pkg::TSM_PORT_W-1:0] pay_port,
    input wire logic [SW-1:0] pay_word_idx,
    input wire logic pay_stuff,
    input wire logic [tsm_pkg::TSM_WORD_W-1:0] pay_data,
    output logic pay_valid,
    output logic pay_hit,
    output logic [SW-1:0] pay_slot,
    output logic [tsm_pkg::TSM_WORD_W-1:0] pay_data_out,
    // Unit sizing
    input wire logic [tsm_pkg::TSM_PORT_W-1:0] size_port,
    output logic [SW-1:0] size_ts,
    output logic [15:0] size_cols,
    output logic [31:0] size_bytes,
    output logic [15:0] size_m,
    output logic [15:0] size_m_over_n
);
    import tsm_pkg::*;

    generate
        if (N_LANES < 1 || N_LANES > 12) begin : g_bad
            $error("N_LANES must lie in 1..12");
        end
    endgenerate

    function automatic logic [TSM_PORT_W-1:0] port_at(input logic [NS*TSM_PORT_W-1:0] v, input int g);
        port_at = v[g*TSM_PORT_W +: TSM_PORT_W];
    endfunction

    function automatic logic [5:0] crc6(input logic [11:0] d);
        logic [5:0] c;
        c = 6'h00;
        for (int i = 11; i >= 0; i--) begin
            c = (c[5] ^ d[i]) ? ({c[4:0], 1'b0} ^ CRC6_POLY) : {c[4:0], 1'b0};
        end
        crc6 = c;
    endfunction

    function automatic logic [8:0] crc9(input logic [17:0] d);
        logic [8:0] c;
        c = 9'h000;
        for (int i = 17; i >= 0; i--) begin
            c = (c[8] ^ d[i]) ? ({c[7:0], 1'b0} ^ CRC9_POLY) : {c[7:0], 1'b0};
        end
        crc9 = c;
    endfunction

    // Multiframe counter
    logic [4:0] mfc_q;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            mfc_q <= TSM_MFC_RST;
        end else if (frame_start) begin
            if (align_en && fa_count == TSM_FA_ALIGN) begin
                mfc_q <= TSM_MFC_RST;
            end else if (mfc_q >= TSM_MFC_LAST) begin
                mfc_q <= TSM_MFC_RST;
            end else begin
                mfc_q <= mfc_q + 5'h01;
            end
        end
    end

    // One byte, copied by the framer into every lane
    assign mfc_byte = {3'h0, mfc_q};
    assign mfc_value = mfc_q;

    // Payload structure bytes
    logic [7:0] psi_d;
    logic [7:0] psi_q;
    logic psi_valid_q;

    always_comb begin
        int g;
        logic [TSM_PORT_W-1:0] p;
        logic [7:0] rel;
        g = 0;
        p = '0;
        rel = psi_pos - TSM_PSI_MSI_FIRST;
        psi_d = TSM_BYTE_RST;
        if (psi_pos == TSM_PSI_PT_POS && psi_lane == 8'h01) begin
            psi_d = TSM_PT_MUX;
        end else if (psi_pos >= TSM_PSI_MSI_FIRST && psi_pos <= TSM_PSI_MSI_LAST &&
                     psi_lane >= 8'h01 && int'(psi_lane) <= N_LANES) begin
            g = N_LANES * int'(rel[7:1]) + int'(psi_lane) - 1;
            p = slot_alloc[g] ? port_at(slot_port, g) : '0;
            if (!rel[0]) begin
                psi_d = {slot_unavail[g], p[13:7]};
            end else begin
                psi_d = {slot_alloc[g], p[6:0]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            psi_q <= TSM_BYTE_RST;
            psi_valid_q <= 1'b0;
        end else begin
            psi_valid_q <= psi_req;
            if (psi_req) begin
                psi_q <= psi_d;
            end
        end
    end

    assign psi_byte = psi_q;
    assign psi_valid = psi_valid_q;

    // Slot overhead: the counter picks slot B, the lane picks A
    logic oh_last;
    logic [TSM_PORT_W-1:0] oh_port;
    logic [7:0] oh_d;
    logic [7:0] oh_q;
    logic oh_valid_q;
    logic [17:0] jc_lo;
    logic [5:0] jc_lo_crc;
    logic [8:0] jc_hi_crc;

    always_comb begin
        int gs;
        gs = 0;
        oh_last = 1'b0;
        oh_port = '0;
        if (oh_lane >= 8'h01 && int'(oh_lane) <= N_LANES) begin
            gs = N_LANES * int'(mfc_q) + int'(oh_lane) - 1;
            if (slot_alloc[gs]) begin
                oh_port = port_at(slot_port, gs);
                oh_last = 1'b1;
                // Only the highest allocated slot of a unit carries its overhead
                for (int g = 0; g < NS; g++) begin
                    if (g > gs && slot_alloc[g] && port_at(slot_port, g) == oh_port) begin
                        oh_last = 1'b0;
                    end
                end
            end
        end
    end

    assign jc_port = oh_port;

    assign jc_lo_crc = crc6({jc_cm, jc_inc, jc_dec});
    assign jc_lo = {jc_cm, jc_inc, jc_dec, jc_lo_crc};
    assign jc_hi_crc = crc9(jc_cnd);

    always_comb begin
        oh_d = TSM_BYTE_RST;
        if (oh_last && oh_row >= TSM_OH_ROW_FIRST && oh_row <= TSM_OH_ROW_LAST) begin
            if (oh_col16) begin
                // Control bytes 1..3: bits 1-2 residual, bits 3-8 count, flags and CRC-6
                unique case (oh_row)
                    2'h1: oh_d = {jc_cnd[17:16], jc_lo[17:12]};
                    2'h2: oh_d = {jc_cnd[15:14], jc_lo[11:6]};
                    default: oh_d = {jc_cnd[13:12], jc_lo[5:0]};
                endcase
            end else begin
                // Control bytes 4..6: bit 1 reserved zero, bits 2-8 residual and check
                unique case (oh_row)
                    2'h1: oh_d = {1'b0, jc_cnd[11:5]};
                    2'h2: oh_d = {1'b0, jc_cnd[4:0], jc_hi_crc[8:7]};
                    default: oh_d = {1'b0, jc_hi_crc[6:0]};
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            oh_q <= TSM_BYTE_RST;
            oh_valid_q <= 1'b0;
        end else begin
            oh_valid_q <= oh_req;
            if (oh_req) begin
                oh_q <= oh_d;
            end
        end
    end

    assign oh_byte = oh_q;
    assign oh_valid = oh_valid_q;

    // Payload word to slot mapping
    logic pay_hit_d;
    logic [SW-1:0] pay_slot_d;
    logic pay_hit_q;
    logic [SW-1:0] pay_slot_q;
    logic [TSM_WORD_W-1:0] pay_data_q;
    logic pay_valid_q;

    always_comb begin
        logic [SW-1:0] rank;
        rank = '0;
        pay_hit_d = 1'b0;
        pay_slot_d = '0;
        for (int g = 0; g < NS; g++) begin
            if (slot_alloc[g] && port_at(slot_port, g) == pay_port) begin
                if (rank == pay_word_idx && !pay_hit_d) begin
                    pay_hit_d = 1'b1;
                    pay_slot_d = SW'(g);
                end
                rank = rank + SW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pay_valid_q <= 1'b0;
            pay_hit_q <= 1'b0;
            pay_slot_q <= '0;
            pay_data_q <= '0;
        end else begin
            pay_valid_q <= pay_req;
            if (pay_req) begin
                pay_hit_q <= pay_hit_d;
                pay_slot_q <= pay_slot_d;
                pay_data_q <= pay_stuff ? '0 : pay_data;
            end
        end
    end

    assign pay_valid = pay_valid_q;
    assign pay_hit = pay_hit_q;
    assign pay_slot = pay_slot_q;
    assign pay_data_out = pay_data_q;

    // Unit sizing
    logic [SW-1:0] ts_d;
    logic [SW-1:0] ts_q;

    always_comb begin
        ts_d = '0;
        for (int g = 0; g < NS; g++) begin
            if (slot_alloc[g] && port_at(slot_port, g) == size_port) begin
                ts_d = ts_d + SW'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ts_q <= '0;
        end else begin
            ts_q <= ts_d;
        end
    end

    assign size_ts = ts_q;
    assign size_cols = 16'(TSM_PAY_COLS_PER_TS * int'(ts_q));
    assign size_bytes = 32'(TSM_PAY_BYTES_PER_TS * int'(ts_q));
    assign size_m = 16'(TSM_M_PER_TS * int'(ts_q));
    assign size_m_over_n = 16'(TSM_M_PER_TS / TSM_N_GRAN * int'(ts_q));

endmodule

`default_nettype wire

// ===== verification/tsm_mux_monitor.sv
// Checker for the tributary slot multiplexer ports
`timescale 1ns/1ps
`default_nettype none
module tsm_mux_monitor #(
    parameter int N_LANES = 1
) (
    // Clock, reset, frame timing
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic frame_start,
    input wire logic [7:0] fa_count,
    input wire logic align_en,
    input wire logic [7:0] mfc_byte,
    input wire logic [4:0] mfc_value,
    // Requests and answers
    input wire logic psi_req,
    input wire logic psi_valid,
    input wire logic oh_req,
    input wire logic oh_valid,
    input wire logic pay_req,
    input wire logic pay_stuff,
    input wire logic [127:0] pay_data,
    input wire logic [127:0] pay_data_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire logic fa_zero = align_en && fa_count == 8'h00;
    property p_mfc_step; frame_start && !fa_zero && mfc_value < 5'h13 |=> mfc_value == $past(mfc_value) + 5'h01; endproperty
    a_mfc_step: assert property (p_mfc_step) else $error("counter did not advance");
    property p_mfc_wrap; frame_start && mfc_value == 5'h13 |=> mfc_value == 5'h00; endproperty
    a_mfc_wrap: assert property (p_mfc_wrap) else $error("counter did not wrap");
    property p_mfc_align; frame_start && fa_zero |=> mfc_value == 5'h00; endproperty
    a_mfc_align: assert property (p_mfc_align) else $error("counter not aligned");
    property p_mfc_lanes; mfc_byte == {3'h0, mfc_value}; endproperty
    a_mfc_lanes: assert property (p_mfc_lanes) else $error("counter byte wrong");
    property p_psi_ans; psi_req |=> psi_valid; endproperty
    a_psi_ans: assert property (p_psi_ans) else $error("structure byte missing");
    property p_oh_ans; oh_req |=> oh_valid; endproperty
    a_oh_ans: assert property (p_oh_ans) else $error("overhead byte missing");
    property p_stuff; pay_req && pay_stuff |=> pay_data_out == 128'h0; endproperty
    a_stuff: assert property (p_stuff) else $error("stuff word not zero");
    property p_pay_data; pay_req && !pay_stuff |=> pay_data_out == $past(pay_data); endproperty
    a_pay_data: assert property (p_pay_data) else $error("payload word changed");
endmodule
bind tsm_mux tsm_mux_monitor #(.N_LANES(N_LANES)) tsm_mux_monitor_i (.clk_sys, .nrst, .frame_start, .fa_count,
    .align_en, .mfc_byte, .mfc_value, .psi_req, .psi_valid, .oh_req, .oh_valid, .pay_req, .pay_stuff, .pay_data,
    .pay_data_out);
`default_nettype wire

// ===== verification/tsm_mapper_model.sv
// Behavioural mapper answering justification values for a port
`timescale 1ns/1ps
`default_nettype none
module tsm_mapper_model (
    input wire logic [13:0] jc_port,
    output logic [9:0] jc_cm,
    output logic jc_inc,
    output logic jc_dec,
    output logic [17:0] jc_cnd
);
    assign jc_cm = jc_port[9:0] ^ 10'h2a5;
    assign {jc_inc, jc_dec} = jc_port[1:0];
    // A fixed value, not a running sum: 4'h9 above the port number, the same every time the port is asked
    assign jc_cnd = {4'h9, jc_port};
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the tributary slot multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tsm_pkg::*;
    localparam int NS = 20;
    // Check polynomials handed to the design, so the bench owns them
    localparam logic [8:0] CRC6_POLY = 9'h021;
    localparam logic [8:0] CRC9_POLY = 9'h101;
    logic clk_sys = 1'b0, nrst = 1'b0, frame_start = 1'b0, align_en = 1'b1, psi_req = 1'b0, oh_req = 1'b0;
    logic oh_col16 = 1'b0, pay_req = 1'b0, pay_stuff = 1'b0, jc_inc, jc_dec, psi_valid, oh_valid, pay_valid, pay_hit;
    logic [7:0] fa_count = 8'h05, psi_lane = 8'h01, psi_pos = 8'h00, oh_lane = 8'h01, mfc_byte, psi_byte, oh_byte;
    logic [1:0] oh_row = 2'h1;
    logic [4:0] mfc_value, pay_word_idx = 5'h00, pay_slot, size_ts, mc = 5'h00;
    logic [NS-1:0] slot_unavail, slot_alloc;
    logic [NS*14-1:0] slot_port;
    logic [13:0] jc_port, pay_port = 14'h0001, size_port = 14'h0001;
    logic [9:0] jc_cm;
    logic [17:0] jc_cnd;
    logic [127:0] pay_data = 128'h0, pay_data_out;
    logic [15:0] size_cols, size_m, size_m_over_n;
    logic [31:0] size_bytes;
    logic [133:0] pe, pay_q[$];
    logic [7:0] psi_q[$], oh_q[$];
    int seed = 90677, err_total = 0, total_checks = 0, ts = 0;

    tsm_mux #(.N_LANES(1), .CRC6_POLY(CRC6_POLY[5:0]), .CRC9_POLY(CRC9_POLY)) tsm_mux_i (.clk_sys, .nrst,
        .frame_start, .fa_count, .align_en, .mfc_byte, .mfc_value,
        .slot_unavail, .slot_alloc, .slot_port, .psi_req, .psi_lane, .psi_pos, .psi_valid, .psi_byte, .oh_req,
        .oh_lane, .oh_row, .oh_col16, .jc_port, .jc_cm, .jc_inc, .jc_dec, .jc_cnd, .oh_valid, .oh_byte, .pay_req,
        .pay_port, .pay_word_idx, .pay_stuff, .pay_data, .pay_valid, .pay_hit, .pay_slot, .pay_data_out,
        .size_port, .size_ts, .size_cols, .size_bytes, .size_m, .size_m_over_n);
    tsm_mapper_model tsm_mapper_model_i (.jc_port, .jc_cm, .jc_inc, .jc_dec, .jc_cnd);

    always #50 clk_sys = ~clk_sys;

    function automatic logic [13:0] pt(int g);
        return slot_alloc[g] ? slot_port[g*14+:14] : 14'h0;
    endfunction
    // Overhead lives only in the highest slot of a port
    function automatic logic last(int g);
        for (int j = g + 1; j < NS; j++) if (pt(j) == pt(g)) return 1'b0;
        return 1'b1;
    endfunction
    function automatic logic [5:0] rank(int r);
        int c = 0;
        for (int g = 0; g < NS; g++) begin
            if (pt(g) == pay_port) begin
                if (c == r) return {1'b1, 5'(g)};
                c++;
            end
        end
        return 6'h0;
    endfunction
    function automatic logic [7:0] exp_psi(int i);
        int k = (i - 2) / 2;
        logic [13:0] q = pt(k);
        if (i == 0) return TSM_PT_MUX;
        if (i < 2 || i > 41) return 8'h00;
        return i[0] ? {slot_alloc[k], q[6:0]} : {slot_unavail[k], q[13:7]};
    endfunction
    // Bit-serial check code, register starts at zero, data taken MSB first
    function automatic logic [8:0] crc(input logic [17:0] d, input int nb, input int w, input logic [8:0] poly);
        logic [8:0] c;
        logic fb;
        c = 9'h000;
        for (int i = nb - 1; i >= 0; i--) begin
            fb = c[w-1] ^ d[i];
            c = ((c << 1) ^ (fb ? poly : 9'h000)) & ((9'h001 << w) - 9'h001);
        end
        return c;
    endfunction
    // Control bytes one to six in order: r 0..2 column 16, r 3..5 column 15
    function automatic logic [7:0] exp_oh(int r, int g);
        logic [13:0] q;
        logic [17:0] d;
        logic [17:0] lo;
        logic [8:0] h;
        logic [47:0] jc;
        q = pt(g);
        d = {4'h9, q};
        lo = {q[9:0] ^ 10'h2a5, q[1:0], 6'(crc({6'h00, q[9:0] ^ 10'h2a5, q[1:0]}, 12, 6, CRC6_POLY))};
        h = crc(d, 18, 9, CRC9_POLY);
        jc = {d[17:16], lo[17:12], d[15:14], lo[11:6], d[13:12], lo[5:0], 1'b0, d[11:5], 1'b0, d[4:0], h[8:7],
            1'b0, h[6:0]};
        if (!slot_alloc[g] || !last(g)) return 8'h00;
        return jc[47 - 8 * r -: 8];
    endfunction

    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(negedge clk_sys) begin
        if (psi_valid === 1'b1) chk("psi_byte", psi_q.pop_front(), psi_byte);
        if (oh_valid === 1'b1) chk("oh_byte", oh_q.pop_front(), oh_byte);
        if (pay_valid === 1'b1) begin
            pe = pay_q.pop_front();
            chk("pay_data_out", pe[127:0], pay_data_out);
            chk("pay_hit", pe[133], pay_hit);
            if (pe[133]) chk("pay_slot", pe[132:128], pay_slot);
        end
    end

    initial begin
        for (int g = 0; g < NS; g++) begin
            slot_alloc[g] = 1'($random(seed));
            slot_unavail[g] = 1'($random(seed));
            slot_port[g*14+:14] = 14'(g % 3 + 1);
            ts += int'(pt(g) == pay_port);
        end
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        // Every structure position of lane 1, then a lane that does not exist
        for (int i = 0; i < 257; i++) begin
            @(negedge clk_sys);
            psi_req = 1'b1;
            psi_lane = i > 255 ? 8'h02 : 8'h01;
            psi_pos = 8'(i);
            psi_q.push_back(exp_psi(i));
        end
        for (int i = 0; i < NS; i++) begin
            @(negedge clk_sys);
            psi_req = 1'b0;
            pay_req = 1'b1;
            pay_word_idx = 5'(i);
            pay_stuff = 1'($random(seed));
            pay_data = {$random(seed), $random(seed), $random(seed), $random(seed)};
            pay_q.push_back({rank(i), pay_stuff ? 128'h0 : pay_data});
        end
        @(negedge clk_sys);
        pay_req = 1'b0;
        chk("size_ts", ts, size_ts);
        chk("size_cols", 119 * ts, size_cols);
        chk("size_bytes", 15232 * ts, size_bytes);
        chk("size_m", 128 * ts, size_m);
        chk("size_m_over_n", 16 * ts, size_m_over_n);
        // Frames walk the counter through alignment, refused alignment and wrap
        for (int f = 0; f < 30; f++) begin
            @(negedge clk_sys);
            frame_start = 1'b1;
            fa_count = (f == 7 || f == 20) ? 8'h00 : 8'h05;
            align_en = f != 20;
            mc = (f == 7 || mc == 5'h13) ? 5'h00 : mc + 5'h01;
            @(negedge clk_sys);
            frame_start = 1'b0;
            chk("mfc_value", mc, mfc_value);
            for (int r = 0; r < 6; r++) begin
                oh_req = 1'b1;
                oh_row = 2'(r % 3 + 1);
                oh_col16 = r < 3;
                #1 chk("jc_port", pt(mc), jc_port);
                oh_q.push_back(exp_oh(r, mc));
                @(negedge clk_sys);
            end
            oh_req = 1'b0;
        end
        repeat (2) @(negedge clk_sys);
        chk("pending", 0, psi_q.size() + oh_q.size() + pay_q.size());
        report_and_stop;
    end

    initial begin
        #2000000;
        err_total++;
        report_and_stop;
    end
endmodule
`default_nettype wire
